//--- hw/tsl_pkg.sv
package tsl_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FILT_TC = 8'h04;
   localparam logic [7:0] ADDR_INT_LIMIT = 8'h08;
   localparam logic [7:0] ADDR_GAIN = 8'h0C;
   localparam logic [7:0] ADDR_PRESET1 = 8'h10;
   localparam logic [7:0] ADDR_PRESET2 = 8'h14;
   localparam logic [7:0] ADDR_PRESET3 = 8'h18;
   localparam logic [7:0] ADDR_MAX_SPEED = 8'h1C;
   localparam logic [7:0] ADDR_OVS_SPEED = 8'h20;
   localparam logic [7:0] ADDR_RATED = 8'h24;
   localparam logic [7:0] ADDR_STATUS = 8'h28;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h2C;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h30;
   localparam logic [7:0] ADDR_TORQUE = 8'h34;
   localparam logic [7:0] ADDR_SPEED = 8'h38;

   // control register fields
   localparam int CTRL_SRC_BIT = 0;
   localparam int CTRL_CEIL_BIT = 1;
   localparam int CTRL_ALT_BIT = 2;
   localparam int CTRL_PIN_BIT = 3;
   localparam int CTRL_METHOD_LSB = 4;
   localparam int CTRL_RESTART_BIT = 15;
   localparam logic [3:0] METHOD_PRESET = 4'h3;

   // interrupt bits
   localparam int IRQ_LIMIT_ON = 0;
   localparam int IRQ_LIMIT_OFF = 1;
   localparam int IRQ_SEL_CHANGE = 2;

   // reset values
   localparam logic [15:0] RST_CTRL = 16'h0000;
   localparam logic [15:0] RST_FILT_TC = 16'h0000;
   localparam logic [15:0] RST_INT_LIMIT = 16'h2710;
   localparam logic [15:0] RST_GAIN = 16'h0258;
   localparam logic [15:0] RST_PRESET1 = 16'h0064;
   localparam logic [15:0] RST_PRESET2 = 16'h00C8;
   localparam logic [15:0] RST_PRESET3 = 16'h012C;
   localparam logic [15:0] RST_MAX_SPEED = 16'h1770;
   localparam logic [15:0] RST_OVS_SPEED = 16'h1B58;
   localparam logic [15:0] RST_RATED = 16'h0BB8;

   // filter step timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int FILT_UNIT_NS = 10000;
   localparam int FILT_TICK_CYC = FILT_UNIT_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      TSL_OP_TORQUE = 2'b01,
      TSL_OP_PRESET = 2'b10
   } tsl_op_mode_t;
endpackage : tsl_pkg

//--- hw/tsl_filt_if.sv
`timescale 1ns/1ps
interface tsl_filt_if;
   logic signed [15:0] x;
   logic [15:0] tc;
   logic tick;
   logic signed [15:0] y_next;
   modport ctl (output x, output tc, output tick, input y_next);
   modport filt (input x, input tc, input tick, output y_next);
endinterface : tsl_filt_if

//--- hw/tsl_torque_filter.sv
`timescale 1ns/1ps
module tsl_torque_filter
   import tsl_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // filter channel
   tsl_filt_if.filt f
);
   typedef struct packed {
      logic signed [31:0] acc;
   } tsl_filt_state_t;

   tsl_filt_state_t s_q;
   tsl_filt_state_t s_d;
   logic signed [32:0] diff;
   logic signed [32:0] step;
   logic signed [17:0] div;

   // one step per tick, or every cycle when tc is 0: acc += (x - acc) / (tc + 1), 16 fraction bits
   always_comb
   begin
      s_d = s_q;
      div = $signed({2'b00, f.tc}) + 18'sh00001;
      diff = $signed({f.x[15], f.x, 16'h0000}) - $signed({s_q.acc[31], s_q.acc});
      step = diff / div;
      if (f.tc == 16'h0000)
      begin
         s_d.acc = {f.x, 16'h0000};
      end
      else if (f.tick)
      begin
         s_d.acc = s_q.acc + step[31:0];
      end
      f.y_next = s_d.acc[31:16];
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end
endmodule : tsl_torque_filter

//--- hw/tsl_speed_limit.sv
`timescale 1ns/1ps
module tsl_speed_limit
   import tsl_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // analog side, already digitised
   input wire logic signed [15:0] torque_ref_in,
   input wire logic signed [15:0] analog_limit_in,
   input wire logic signed [15:0] motor_speed_in,
   // discrete inputs, 1 = on
   input wire logic direction_select_in,
   input wire logic speed_select_a_in,
   input wire logic speed_select_b_in,
   input wire logic alt_direction_in,
   input wire logic alt_speed_select_a_in,
   input wire logic alt_speed_select_b_in,
   // drive outputs
   output logic signed [15:0] torque_cmd_out,
   output logic signed [15:0] speed_cmd_out,
   output logic preset_run_out,
   output logic speed_limit_active_out,
   output logic irq
);
   typedef struct packed {
      logic [15:0] ctrl_pend;
      logic [15:0] ctrl_act;
      logic started;
      logic [15:0] torque_filter_time_constant;
      logic [15:0] internal_speed_limit;
      logic [15:0] analog_speed_input_gain;
      logic [15:0] preset_speed_one;
      logic [15:0] preset_speed_two;
      logic [15:0] preset_speed_three;
      logic [15:0] max_speed;
      logic [15:0] ovs_speed;
      logic [15:0] rated_speed;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic [9:0] tick_cnt;
      logic tick;
      tsl_op_mode_t mode;
      logic clamp;
      logic [2:0] sel_prev;
      logic signed [15:0] torque_out;
      logic signed [15:0] speed_cmd;
      logic preset_run;
      logic limit_pin;
      logic irq;
      logic [31:0] rdata;
   } tsl_state_t;

   localparam logic [9:0] TICK_LAST = 10'(FILT_TICK_CYC - 1);

   tsl_state_t s_q;
   tsl_state_t s_d;
   tsl_filt_if fch ();

   function automatic logic [15:0] abs16(input logic signed [15:0] v);
      logic [16:0] w;
      w = v[15] ? 17'(-$signed({v[15], v})) : {1'b0, v};
      abs16 = (w[16]) ? 16'hFFFF : w[15:0];
   endfunction : abs16

   function automatic logic [15:0] min16(input logic [15:0] a,
                                         input logic [15:0] b);
      min16 = (a < b) ? a : b;
   endfunction : min16

   function automatic logic [1:0] preset_index(input logic sel_a,
                                               input logic sel_b);
      case ({sel_a, sel_b})
         2'b01: preset_index = 2'h1;
         2'b11: preset_index = 2'h2;
         2'b10: preset_index = 2'h3;
         default: preset_index = 2'h0;
      endcase
   endfunction : preset_index

   logic [15:0] ceiling;
   logic [15:0] eff_int_limit;
   logic [31:0] ext_prod;
   logic [31:0] ext_quot;
   logic [15:0] ext_limit;
   logic [15:0] active_limit;
   logic [15:0] spd_abs;
   logic over_limit;
   logic push_out;
   logic dir_on;
   logic sel_a;
   logic sel_b;
   logic [1:0] pidx;
   logic [15:0] preset_raw;
   logic [15:0] preset_mag;
   logic [2:0] ev;
   logic [2:0] w1c;
   logic [15:0] status_word;
   logic [15:0] rd_val;
   logic restart;
   logic [15:0] gain_div;

   assign fch.x = torque_ref_in;
   assign fch.tc = s_q.torque_filter_time_constant;
   assign fch.tick = s_q.tick;

   tsl_torque_filter u_filter (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .f (fch.filt)
   );

   always_comb
   begin
      s_d = s_q;
      w1c = 3'h0;
      restart = !s_q.started;
      // register writes
      if (reg_wr)
      begin
         case (reg_addr)
            ADDR_CTRL:
            begin
               s_d.ctrl_pend = {1'b0, reg_wdata[14:0]};
               restart = restart | reg_wdata[CTRL_RESTART_BIT];
            end
            ADDR_FILT_TC: s_d.torque_filter_time_constant = reg_wdata[15:0];
            ADDR_INT_LIMIT: s_d.internal_speed_limit = reg_wdata[15:0];
            ADDR_GAIN: s_d.analog_speed_input_gain = reg_wdata[15:0];
            ADDR_PRESET1: s_d.preset_speed_one = reg_wdata[15:0];
            ADDR_PRESET2: s_d.preset_speed_two = reg_wdata[15:0];
            ADDR_PRESET3: s_d.preset_speed_three = reg_wdata[15:0];
            ADDR_MAX_SPEED: s_d.max_speed = reg_wdata[15:0];
            ADDR_OVS_SPEED: s_d.ovs_speed = reg_wdata[15:0];
            ADDR_RATED: s_d.rated_speed = reg_wdata[15:0];
            ADDR_IRQ_STAT: w1c = reg_wdata[2:0];
            ADDR_IRQ_MASK: s_d.irq_mask = reg_wdata[2:0];
            default: ;
         endcase
      end
      // restart-class settings take the pending copy only on restart
      if (restart)
      begin
         s_d.started = 1'b1;
         s_d.ctrl_act = s_d.ctrl_pend;
         if (s_d.ctrl_pend[CTRL_METHOD_LSB +: 4] == METHOD_PRESET)
         begin
            s_d.mode = TSL_OP_PRESET;
         end
         else
         begin
            s_d.mode = TSL_OP_TORQUE;
         end
      end

      // filter step enable, one pulse per 0.01 ms
      if (s_q.tick_cnt == TICK_LAST)
      begin
         s_d.tick_cnt = 10'h000;
         s_d.tick = 1'b1;
      end
      else
      begin
         s_d.tick_cnt = s_q.tick_cnt + 10'h001;
         s_d.tick = 1'b0;
      end

      // limit value
      if (s_q.ctrl_act[CTRL_CEIL_BIT])
      begin
         ceiling = s_q.ovs_speed;
      end
      else
      begin
         ceiling = s_q.max_speed;
      end
      eff_int_limit = min16(ceiling, s_q.internal_speed_limit);
      // zero gain would divide by zero; treat as the smallest step
      gain_div = (s_q.analog_speed_input_gain == 16'h0000) ? 16'h0001
                 : s_q.analog_speed_input_gain;
      ext_prod = abs16(analog_limit_in) * s_q.rated_speed;
      ext_quot = ext_prod / {16'h0000, gain_div};
      ext_limit = (ext_quot[31:16] != 16'h0000) ? 16'hFFFF : ext_quot[15:0];
      if (s_q.ctrl_act[CTRL_SRC_BIT])
      begin
         active_limit = min16(ext_limit, eff_int_limit);
      end
      else
      begin
         active_limit = eff_int_limit;
      end

      // clamp: cut torque that would drive speed further past the limit
      spd_abs = abs16(motor_speed_in);
      over_limit = spd_abs > active_limit;
      push_out = (!motor_speed_in[15] && fch.y_next > 16'sh0000)
                 || (motor_speed_in[15] && fch.y_next < 16'sh0000);

      // preset selection
      if (s_q.ctrl_act[CTRL_ALT_BIT])
      begin
         dir_on = alt_direction_in;
         sel_a = alt_speed_select_a_in;
         sel_b = alt_speed_select_b_in;
      end
      else
      begin
         dir_on = direction_select_in;
         sel_a = speed_select_a_in;
         sel_b = speed_select_b_in;
      end
      pidx = preset_index(sel_a, sel_b);
      case (pidx)
         2'h1: preset_raw = s_q.preset_speed_one;
         2'h2: preset_raw = s_q.preset_speed_two;
         2'h3: preset_raw = s_q.preset_speed_three;
         default: preset_raw = 16'h0000;
      endcase
      preset_mag = min16(preset_raw, s_q.max_speed);

      case (s_q.mode)
         TSL_OP_PRESET:
         begin
            s_d.clamp = 1'b0;
            s_d.torque_out = 16'sh0000;
            s_d.preset_run = 1'b1;
            if (dir_on)
            begin
               s_d.speed_cmd = 16'(-$signed({1'b0, preset_mag}));
            end
            else
            begin
               s_d.speed_cmd = $signed(preset_mag);
            end
         end
         default:
         begin
            s_d.clamp = over_limit;
            s_d.preset_run = 1'b0;
            s_d.speed_cmd = 16'sh0000;
            if (over_limit && push_out)
            begin
               s_d.torque_out = 16'sh0000;
            end
            else
            begin
               s_d.torque_out = fch.y_next;
            end
         end
      endcase
      // output only when the pin assignment is enabled
      s_d.limit_pin = s_d.clamp & s_q.ctrl_act[CTRL_PIN_BIT];
      s_d.sel_prev = {dir_on, sel_a, sel_b};

      // events; a set in the cycle of its clear wins
      ev[IRQ_LIMIT_ON] = s_d.clamp & ~s_q.clamp;
      ev[IRQ_LIMIT_OFF] = ~s_d.clamp & s_q.clamp;
      ev[IRQ_SEL_CHANGE] = (s_q.mode == TSL_OP_PRESET)
                           && (s_d.sel_prev != s_q.sel_prev);
      s_d.irq_stat = (s_q.irq_stat & ~w1c) | ev;
      s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

      // register reads, data in the following cycle only
      status_word = {12'h000, s_q.sel_prev[2], s_q.preset_run,
                     s_q.clamp, s_q.mode == TSL_OP_PRESET};
      case (reg_addr)
         ADDR_CTRL: rd_val = s_q.ctrl_pend;
         ADDR_FILT_TC: rd_val = s_q.torque_filter_time_constant;
         ADDR_INT_LIMIT: rd_val = s_q.internal_speed_limit;
         ADDR_GAIN: rd_val = s_q.analog_speed_input_gain;
         ADDR_PRESET1: rd_val = s_q.preset_speed_one;
         ADDR_PRESET2: rd_val = s_q.preset_speed_two;
         ADDR_PRESET3: rd_val = s_q.preset_speed_three;
         ADDR_MAX_SPEED: rd_val = s_q.max_speed;
         ADDR_OVS_SPEED: rd_val = s_q.ovs_speed;
         ADDR_RATED: rd_val = s_q.rated_speed;
         ADDR_STATUS: rd_val = status_word;
         ADDR_IRQ_STAT: rd_val = {13'h0000, s_q.irq_stat};
         ADDR_IRQ_MASK: rd_val = {13'h0000, s_q.irq_mask};
         ADDR_TORQUE: rd_val = s_q.torque_out;
         ADDR_SPEED: rd_val = s_q.speed_cmd;
         default: rd_val = 16'h0000;
      endcase
      s_d.rdata = reg_rd ? {16'h0000, rd_val} : 32'h0000_0000;
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s_q <= '0;
         s_q.ctrl_pend <= RST_CTRL;
         s_q.ctrl_act <= RST_CTRL;
         s_q.torque_filter_time_constant <= RST_FILT_TC;
         s_q.internal_speed_limit <= RST_INT_LIMIT;
         s_q.analog_speed_input_gain <= RST_GAIN;
         s_q.preset_speed_one <= RST_PRESET1;
         s_q.preset_speed_two <= RST_PRESET2;
         s_q.preset_speed_three <= RST_PRESET3;
         s_q.max_speed <= RST_MAX_SPEED;
         s_q.ovs_speed <= RST_OVS_SPEED;
         s_q.rated_speed <= RST_RATED;
         s_q.mode <= TSL_OP_TORQUE;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign reg_rdata = s_q.rdata;
   assign torque_cmd_out = s_q.torque_out;
   assign speed_cmd_out = s_q.speed_cmd;
   assign preset_run_out = s_q.preset_run;
   assign speed_limit_active_out = s_q.limit_pin;
   assign irq = s_q.irq;
endmodule : tsl_speed_limit

//--- tb/tsl_speed_limit_asserts.sv
`timescale 1ns/1ps
module tsl_sl_asserts (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // pins in
   input wire logic signed [15:0] motor_speed_in,
   input wire logic direction_select_in,
   input wire logic speed_select_a_in,
   input wire logic speed_select_b_in,
   input wire logic alt_direction_in,
   input wire logic alt_speed_select_a_in,
   input wire logic alt_speed_select_b_in,
   // pins out
   input wire logic signed [15:0] torque_cmd_out,
   input wire logic signed [15:0] speed_cmd_out,
   input wire logic preset_run_out,
   input wire logic speed_limit_active_out,
   input wire logic irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   logic sel_off;
   logic dir_fwd;
   logic dir_rev;
   // both pin sets must agree, so either allocation is covered
   assign sel_off = !(speed_select_a_in | speed_select_b_in |
      alt_speed_select_a_in | alt_speed_select_b_in);
   assign dir_fwd = !(direction_select_in | alt_direction_in);
   assign dir_rev = direction_select_in & alt_direction_in;
   property preset_hold(logic c, logic ok);
      preset_run_out && $past(preset_run_out) && $past(c) |-> ok;
   endproperty
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its slot");
   a_preset_torque: assert property (
      preset_run_out |-> torque_cmd_out == 16'sh0)
      else $error("torque driven in preset mode");
   a_torque_speed: assert property (
      !preset_run_out |-> speed_cmd_out == 16'sh0)
      else $error("speed command outside preset mode");
   a_mode_restart: assert property (
      $changed(preset_run_out) |-> $past(reg_wr) || $past(reg_wr, 2))
      else $error("mode changed without a restart");
   a_preset_stop: assert property (preset_hold(sel_off,
      speed_cmd_out == 16'sh0)) else $error("stop code gave a speed");
   a_preset_fwd: assert property (preset_hold(dir_fwd,
      speed_cmd_out >= 16'sh0)) else $error("forward gave reverse");
   a_preset_rev: assert property (preset_hold(dir_rev,
      speed_cmd_out <= 16'sh0)) else $error("reverse gave forward");
   a_limit_cause: assert property (
      speed_limit_active_out |-> $past(motor_speed_in) != 16'sh0)
      else $error("limit active at standstill");
   a_clamp_torque: assert property (
      speed_limit_active_out && $past(motor_speed_in) > 16'sh0
      |-> torque_cmd_out <= 16'sh0) else $error("clamp kept drive torque");
   c_preset_run: cover property (preset_run_out && speed_cmd_out != 16'sh0);
   c_limit_on: cover property ($rose(speed_limit_active_out));
   c_irq_on: cover property ($rose(irq));
endmodule : tsl_sl_asserts

bind tsl_speed_limit tsl_sl_asserts u_chk (.sys_clk, .reset_n, .reg_wr,
   .reg_rd, .reg_rdata, .motor_speed_in, .direction_select_in,
   .speed_select_a_in, .speed_select_b_in, .alt_direction_in,
   .alt_speed_select_a_in, .alt_speed_select_b_in, .torque_cmd_out,
   .speed_cmd_out, .preset_run_out, .speed_limit_active_out, .irq);

//--- tb/tsl_host_model.sv
`timescale 1ns/1ps
module tsl_host_model (
   // clock
   input wire logic sys_clk,
   // bench commands
   input wire logic dir_c,
   input wire logic sel_a_c,
   input wire logic sel_b_c,
   input wire logic alt_c,
   input wire logic scr_c,
   input wire logic signed [15:0] lim_cmd,
   // discrete and analog pins
   output logic direction_select_in,
   output logic speed_select_a_in,
   output logic speed_select_b_in,
   output logic alt_direction_in,
   output logic alt_speed_select_a_in,
   output logic alt_speed_select_b_in,
   output logic signed [15:0] analog_limit_in
);
   logic [2:0] live;
   logic [2:0] idle;
   assign live = {dir_c, sel_a_c, sel_b_c};
   // unused set may carry the inverse so a wrong decode shows up
   assign idle = live ^ {3{scr_c}};
   // pins take their first value on the first edge, inside bench reset
   always @(posedge sys_clk)
   begin
      {direction_select_in, speed_select_a_in, speed_select_b_in} <=
         alt_c ? idle : live;
      {alt_direction_in, alt_speed_select_a_in, alt_speed_select_b_in} <=
         alt_c ? live : idle;
      analog_limit_in <= lim_cmd;
   end
endmodule : tsl_host_model

//--- tb/tsl_speed_limit_tb.sv
`timescale 1ns/1ps
module tsl_speed_limit_tb
   import tsl_pkg::*;
;
   logic sys_clk, reset_n, reg_wr, reg_rd;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic signed [15:0] torque_ref_in, motor_speed_in, analog_limit_in;
   logic signed [15:0] lim_cmd, torque_cmd_out, speed_cmd_out;
   logic dir_c, sel_a_c, sel_b_c, alt_c, scr_c;
   logic direction_select_in, speed_select_a_in, speed_select_b_in;
   logic alt_direction_in, alt_speed_select_a_in, alt_speed_select_b_in;
   logic preset_run_out, speed_limit_active_out, irq;
   int miscompares = 0;
   int cmp_count = 0;
   // speed per select code {a,b}: stop, one, three, two
   int pre_tbl [4] = '{32'h0, 32'h64, 32'h12C, 32'hC8};

   tsl_speed_limit DUT (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .torque_ref_in, .analog_limit_in,
      .motor_speed_in, .direction_select_in, .speed_select_a_in,
      .speed_select_b_in, .alt_direction_in, .alt_speed_select_a_in,
      .alt_speed_select_b_in, .torque_cmd_out, .speed_cmd_out,
      .preset_run_out, .speed_limit_active_out, .irq);
   tsl_host_model u_host (.sys_clk, .dir_c, .sel_a_c, .sel_b_c, .alt_c,
      .scr_c, .lim_cmd, .direction_select_in, .speed_select_a_in,
      .speed_select_b_in, .alt_direction_in, .alt_speed_select_a_in,
      .alt_speed_select_b_in, .analog_limit_in);

   task automatic chk(input string nm, input logic signed [31:0] seen,
      input logic signed [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %0d seen %0d", nm, exp, seen);
      end
   endtask : chk
   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim
   // every driver starts on a fresh edge, so strobes never collide
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge sys_clk);
      reg_wr <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge sys_clk);
      reg_rd <= 1'h0;
      @(negedge sys_clk);
      chk("reg_rdata", reg_rdata, e);
   endtask : rd
   task automatic look(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask : look
   task automatic setin(input logic signed [15:0] s, t);
      @(posedge sys_clk);
      motor_speed_in <= s;
      torque_ref_in <= t;
   endtask : setin
   task automatic host(input logic d, a, b, alt, scr);
      @(posedge sys_clk);
      {dir_c, sel_a_c, sel_b_c, alt_c, scr_c} <= {d, a, b, alt, scr};
   endtask : host
   task automatic lim_chk(input logic signed [15:0] s, input logic e);
      setin(s, 16'sh1F4);
      look(1);
      chk("limit_active", speed_limit_active_out, e);
   endtask : lim_chk

   task automatic t_defaults();
      rd(ADDR_FILT_TC, 32'h0);
      rd(ADDR_INT_LIMIT, 32'h2710);
      rd(ADDR_GAIN, 32'h258);
      rd(ADDR_PRESET1, 32'h64);
      rd(ADDR_PRESET2, 32'hC8);
      rd(ADDR_PRESET3, 32'h12C);
      rd(8'h3C, 32'h0);
   endtask : t_defaults
   task automatic t_internal();
      wr(ADDR_CTRL, 32'h8008);
      wr(ADDR_INT_LIMIT, 32'h1F4);
      wr(ADDR_IRQ_MASK, 32'h1);
      lim_chk(16'sh1F5, 1'h1);
      chk("torque_cut", torque_cmd_out, 32'sh0);
      lim_chk(16'sh1F3, 1'h0);
      chk("torque_pass", torque_cmd_out, 32'sh1F4);
      chk("irq_set", irq, 1'h1);
      wr(ADDR_IRQ_STAT, 32'h1);
      look(1);
      chk("irq_clr", irq, 1'h0);
      wr(ADDR_INT_LIMIT, 32'h2710);
      lim_chk(16'sh1771, 1'h1);
      lim_chk(16'sh176F, 1'h0);
      wr(ADDR_CTRL, 32'h000A);
      lim_chk(16'sh1964, 1'h1);
      wr(ADDR_CTRL, 32'h800A);
      lim_chk(16'sh1964, 1'h0);
      lim_chk(16'sh1B59, 1'h1);
   endtask : t_internal
   task automatic t_external();
      @(posedge sys_clk);
      lim_cmd <= -16'sh12C;
      wr(ADDR_CTRL, 32'h8009);
      lim_chk(16'sh5DD, 1'h1);
      lim_chk(16'sh5DB, 1'h0);
      wr(ADDR_INT_LIMIT, 32'h3E8);
      lim_chk(16'sh3E9, 1'h1);
      wr(ADDR_INT_LIMIT, 32'h2710);
      wr(ADDR_GAIN, 32'h4B0);
      lim_chk(16'sh2EF, 1'h1);
      lim_chk(-16'sh2ED, 1'h0);
   endtask : t_external
   task automatic t_filter();
      wr(ADDR_CTRL, 32'h8000);
      lim_chk(16'sh1771, 1'h0);
      chk("torque_cut_nopin", torque_cmd_out, 32'sh0);
      setin(16'sh0, 16'sh4D2);
      look(1);
      chk("torque_thru", torque_cmd_out, 32'sh4D2);
      wr(ADDR_FILT_TC, 32'h1);
      setin(16'sh0, 16'sh7D0);
      look(1);
      chk("lag_start", torque_cmd_out < 16'sh7D0, 1'h1);
      look(20000);
      chk("lag_end", torque_cmd_out > 16'sh7CD, 1'h1);
      wr(ADDR_FILT_TC, 32'h0);
      setin(16'sh0, 16'sh64);
      look(1);
      chk("tc_now", torque_cmd_out, 32'sh64);
   endtask : t_filter
   task automatic t_preset();
      int e;
      setin(16'sh0, 16'sh0);
      wr(ADDR_CTRL, 32'h0030);
      look(2);
      chk("mode_wait", preset_run_out, 1'h0);
      wr(ADDR_CTRL, 32'h8030);
      look(2);
      chk("mode_on", preset_run_out, 1'h1);
      chk("torque_off", torque_cmd_out, 32'sh0);
      for (int i = 0; i < 8; i++)
      begin
         host(i[2], i[1], i[0], 1'h0, 1'h0);
         look(2);
         e = pre_tbl[i[1:0]];
         chk("preset", speed_cmd_out, i[2] ? -e : e);
      end
      wr(ADDR_PRESET3, 32'h2328);
      host(1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
      look(2);
      chk("preset_cap", speed_cmd_out, 32'sh1770);
      wr(ADDR_CTRL, 32'h8034);
      host(1'h1, 1'h0, 1'h1, 1'h1, 1'h1);
      look(2);
      chk("alt_pins", speed_cmd_out, -32'sh64);
      rd(ADDR_STATUS, 32'hD);
      rd(ADDR_IRQ_STAT, 32'h7);
      wr(ADDR_IRQ_STAT, 32'h7);
      rd(ADDR_IRQ_STAT, 32'h0);
      wr(ADDR_PRESET1, 32'h96);
      look(1);
      chk("preset_now", speed_cmd_out, -32'sh96);
      wr(ADDR_CTRL, 32'h8000);
      look(2);
      chk("speed_off", speed_cmd_out, 32'sh0);
   endtask : t_preset

   initial
   begin
      sys_clk = 1'h0;
      forever #5 sys_clk = ~sys_clk;
   end
   // tests need about 20000 cycles
   initial
   begin
      #600000;
      miscompares++;
      end_sim();
   end
   initial
   begin
      reset_n = 1'h0;
      {reg_addr, reg_wdata, reg_wr, reg_rd} = 42'h0;
      {torque_ref_in, motor_speed_in, lim_cmd} = 48'h0;
      {dir_c, sel_a_c, sel_b_c, alt_c, scr_c} = 5'h0;
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'h1;
      t_defaults();
      $display("defaults test done");
      t_internal();
      $display("internal limit test done");
      t_external();
      $display("external limit test done");
      t_filter();
      $display("filter test done");
      t_preset();
      $display("preset test done");
      end_sim();
   end
endmodule : tsl_speed_limit_tb
